//--- hw/imr_master.sv
/*
 * two-wire master: repeated start, byte transmit, byte receive.
 * assumes open-drain pins resolved outside; link clock is the quarter-cycle clock.
 */
// What this block does
// RULE1: buffer write while busy sets write collision, buffer kept.
// RULE2: request-bit writes ignored until repeated start completes.
// RULE3: repeat-start request from idle first drives clock low.
// RULE4: clock seen low: load counter from reload 5:0, release data.
// RULE5: timeout with data high releases clock; clock high reloads 6:0.
// RULE6: data driven low one period; request self-clears; data stays low.
// RULE7: start seen flagged at once; event flag waits for timeout.
// RULE8: repeat-start request ignored while another event runs.
// RULE9: collision if data low at clock rise or clock falls early.
// RULE10: host then loads the address byte, then more address or data.
// RULE11: buffer write sets buffer full and starts the baud counter.
// RULE12: data changes after clock fall; clock low then high one period each.
// RULE13: eighth clock fall clears buffer full and releases data.
// RULE14: ninth clock fall samples data into ack received bit.
// RULE15: after ninth clock: event flag, counter stops, clock low.
// RULE16: address byte: seven bits then read/write bit, msb first.
// RULE17: host clears write collision; hardware clears it only at reset.
// RULE18: receive request taken only when idle.
// RULE19: receive toggles clock each rollover and shifts data in.
// RULE20: after eighth receive clock: buffer loaded, full, event, idle.
// RULE21: reading the buffer clears buffer full.
// RULE22: host may then request an acknowledge sequence; this block has no acknowledge request and ignores the write.
// RULE23: repeated-start collision aborts, releases lines, clears requests.
// RULE24: counter counts down twice per instruction cycle.
// RULE25: reload taken from low seven bits of the reload register.
// RULE26: reset clears requests and flags, releases lines, idles.
`timescale 1ns/100ps
module imr_master
(
   input  wire logic                          clk_sys_in,
   input  wire logic                          reset_in,
   input  wire logic                          clk_link_in,
   input  wire logic                          wr_buffer_in,
   input  wire logic [7:0]                    wr_data_in,
   input  wire logic                          rd_buffer_in,
   input  wire logic                          ctrl_wr_in,
   input  wire logic [imr_pkg::REQ_W-1:0]     ctrl_data_in,
   input  wire logic [imr_pkg::BAUD_W-1:0]    baud_reload_in,
   input  wire logic                          write_collision_flag_clear_in,
   input  wire logic                          event_clear_in,
   input  wire logic                          coll_clear_in,
   output logic [7:0]                         rd_data_out,
   output imr_pkg::imr_status_t               status_out,
   output logic [imr_pkg::REQ_W-1:0]          request_out,
   input  wire logic                          scl_in,
   output logic                               scl_out,
   output logic                               scl_oe_n_out,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe_n_out
);
   import imr_pkg::*;

   function automatic logic [BAUD_W-1:0] baud_load(input logic [BAUD_W-1:0] r, input logic short_load);
      baud_load = short_load ? {1'b0, r[RS_LOAD_W-1:0]} : r;
   endfunction : baud_load

   // host domain
   imr_req_t          cmd;
   logic              cmd_tgl;
   logic              done_s1, done_s2, done_seen;
   logic              start_s1, start_s2, start_seen_q;
   logic              bfclr_s1, bfclr_s2, bfclr_seen;
   logic              busy, done_now, start_now, bfclr_now, wr_ok, rs_go, rx_go;
   logic [REQ_W-1:0]  request;
   logic [7:0]        buffer;
   imr_status_t       status;

   // link domain
   imr_state_t         state;
   imr_res_t           res;
   logic               lrst1, lrst2;
   logic               scl1, scl2, sda1, sda2, sda_prev;
   logic               c1, c2, c_seen, go, rx_mode;
   logic [1:0]         phase;
   logic               tick, tmo;
   logic [BAUD_W-1:0]  cnt;
   logic [3:0]         bitn;
   logic [7:0]         shreg;
   logic               scl_rel, sda_rel;
   logic               done_tgl, start_tgl, bfclr_tgl;

   // an operation is open from launch until its completion toggle returns
   assign busy      = cmd_tgl ^ done_seen;
   assign done_now  = done_s2 ^ done_seen;
   assign start_now = start_s2 ^ start_seen_q;
   assign bfclr_now = bfclr_s2 ^ bfclr_seen;
   assign wr_ok     = wr_buffer_in && !busy;
   assign rs_go     = ctrl_wr_in && !busy && !wr_buffer_in && ctrl_data_in[REQ_RS_BIT];  // [RULE8]
   assign rx_go     = ctrl_wr_in && !busy && !wr_buffer_in && !ctrl_data_in[REQ_RS_BIT]
                      && ctrl_data_in[REQ_RX_BIT];                                      // [RULE18]

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         done_s1  <= 1'b0;
         done_s2  <= 1'b0;
         start_s1 <= 1'b0;
         start_s2 <= 1'b0;
         bfclr_s1 <= 1'b0;
         bfclr_s2 <= 1'b0;
      end
      else
      begin
         done_s1  <= done_tgl;
         done_s2  <= done_s1;
         start_s1 <= start_tgl;
         start_s2 <= start_s1;
         bfclr_s1 <= bfclr_tgl;
         bfclr_s2 <= bfclr_s1;
      end
   end

   // payload stays still while the toggle is open, so the link may read it directly
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         cmd_tgl      <= 1'b0;
         cmd          <= '0;
         done_seen    <= 1'b0;
         start_seen_q <= 1'b0;
         bfclr_seen   <= 1'b0;
      end
      else
      begin
         done_seen    <= done_s2;
         start_seen_q <= start_s2;
         bfclr_seen   <= bfclr_s2;
         if (wr_ok || rs_go || rx_go)
         begin
            cmd_tgl     <= ~cmd_tgl;                                        // [RULE11]
            cmd.kind    <= wr_ok ? IMR_CMD_TX : (rs_go ? IMR_CMD_RS : IMR_CMD_RX);
            cmd.reload  <= baud_reload_in;                                  // [RULE25]
            cmd.data    <= wr_data_in;
         end
      end
   end

   // request bits: writes while busy fall away, so nothing queues
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         request <= '0;                                                      // [RULE26]
      else if (done_now)
         request <= '0;                                                      // [RULE6] [RULE20] [RULE23]
      else if (rs_go)
         request[REQ_RS_BIT] <= 1'b1;                                        // [RULE2]
      else if (rx_go)
         request[REQ_RX_BIT] <= 1'b1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         buffer <= BYTE_ZERO;
         status <= '0;
      end
      else
      begin
         if (write_collision_flag_clear_in)
            status.write_collision_flag <= 1'b0;                            // [RULE17]
         if (wr_buffer_in && busy)
            status.write_collision_flag <= 1'b1;                            // [RULE1]
         if (event_clear_in)
            status.port_event_flag <= 1'b0;
         if (coll_clear_in)
            status.collision_flag <= 1'b0;
         if (rd_buffer_in || bfclr_now)
            status.buffer_full_flag <= 1'b0;                                // [RULE13] [RULE21]
         if (start_now)
            status.start_seen <= 1'b1;                                      // [RULE7]
         if (wr_ok)
         begin
            buffer                  <= wr_data_in;
            status.buffer_full_flag <= 1'b1;                                // [RULE11]
         end
         if (done_now)
         begin
            if (res.coll)
            begin
               status.collision_flag   <= 1'b1;                             // [RULE23]
               status.start_seen       <= 1'b0;
               status.buffer_full_flag <= 1'b0;
            end
            else
            begin
               status.port_event_flag <= 1'b1;                              // [RULE7] [RULE15]
               if (cmd.kind == IMR_CMD_TX)
                  status.ack_received_bit <= res.ack;                       // [RULE14]
               if (cmd.kind == IMR_CMD_RX)
               begin
                  buffer                  <= res.data;                      // [RULE20]
                  status.buffer_full_flag <= 1'b1;
               end
            end
         end
      end
   end

   assign rd_data_out  = buffer;
   assign status_out   = status;
   assign request_out  = request;
   assign scl_out      = 1'b0;
   assign sda_out      = 1'b0;
   assign scl_oe_n_out = scl_rel;
   assign sda_oe_n_out = sda_rel;

   // link domain: reset, pins and command toggle all pass two flops first
   always_ff @(posedge clk_link_in)
   begin
      lrst1 <= reset_in;
      lrst2 <= lrst1;
   end

   always_ff @(posedge clk_link_in)
   begin
      if (lrst2)
      begin
         scl1 <= 1'b1;
         scl2 <= 1'b1;
         sda1 <= 1'b1;
         sda2 <= 1'b1;
         c1   <= 1'b0;
         c2   <= 1'b0;
      end
      else
      begin
         scl1 <= scl_in;
         scl2 <= scl1;
         sda1 <= sda_in;
         sda2 <= sda1;
         c1   <= cmd_tgl;
         c2   <= c1;
      end
   end

   // two of the four quarter clocks decrement the counter
   assign tick = phase[0];                                                   // [RULE24]
   assign tmo  = tick && (cnt == BAUD_ZERO);
   assign go   = c2 ^ c_seen;

   always_ff @(posedge clk_link_in)
   begin
      if (lrst2)
         phase <= PHASE_FIRST;
      else
         phase <= phase + 2'h1;
   end

   always_ff @(posedge clk_link_in)
   begin
      if (lrst2)
      begin
         sda_prev  <= 1'b1;
         start_tgl <= 1'b0;
      end
      else
      begin
         sda_prev <= sda2;
         if (scl2 && sda_prev && !sda2)
            start_tgl <= ~start_tgl;                                         // [RULE7]
      end
   end

   always_ff @(posedge clk_link_in)
   begin
      if (lrst2)
      begin
         state     <= IMR_IDLE;
         c_seen    <= 1'b0;
         cnt       <= BAUD_ZERO;
         bitn      <= BIT_FIRST;
         shreg     <= BYTE_ZERO;
         rx_mode   <= 1'b0;
         scl_rel   <= 1'b1;                                                  // [RULE26]
         sda_rel   <= 1'b1;
         done_tgl  <= 1'b0;
         bfclr_tgl <= 1'b0;
         res       <= '0;
      end
      else
      begin
         // counter runs only while counting states wait on it
         if (tick && cnt != BAUD_ZERO && state != IMR_IDLE && state != IMR_RS_LOW
             && state != IMR_RS_SCLUP && state != IMR_BIT_UP)
            cnt <= cnt - 7'h01;                                             // [RULE24]
         case (state)
            IMR_IDLE:
               if (go)
               begin
                  c_seen  <= c2;
                  scl_rel <= 1'b0;                                           // [RULE3] [RULE12]
                  bitn    <= BIT_FIRST;
                  rx_mode <= (cmd.kind == IMR_CMD_RX);
                  cnt     <= baud_load(cmd.reload, 1'b0);                   // [RULE11]
                  if (cmd.kind == IMR_CMD_RS)
                     state <= IMR_RS_LOW;
                  else
                  begin
                     shreg   <= cmd.data;
                     // clock may still be high after a repeated start: a data move now would be a stop
                     if (cmd.kind == IMR_CMD_RX)
                        sda_rel <= 1'b1;
                     else if (!scl2)
                        sda_rel <= cmd.data[7];                              // [RULE16]
                     state   <= IMR_BIT_LOW;
                  end
               end
            IMR_RS_LOW:
               if (!scl2)
               begin
                  cnt     <= baud_load(cmd.reload, 1'b1);                   // [RULE4]
                  sda_rel <= 1'b1;
                  state   <= IMR_RS_SDAHI;
               end
            IMR_RS_SDAHI:
               if (tmo)
               begin
                  if (sda2)
                  begin
                     scl_rel <= 1'b1;                                        // [RULE5]
                     state   <= IMR_RS_SCLUP;
                  end
                  else
                  begin
                     // another driver holds data low: give up the bus
                     sda_rel  <= 1'b1;
                     scl_rel  <= 1'b1;
                     res.coll <= 1'b1;
                     done_tgl <= ~done_tgl;
                     state    <= IMR_IDLE;
                  end
               end
            IMR_RS_SCLUP:
               if (scl2)
               begin
                  if (!sda2)
                  begin
                     sda_rel  <= 1'b1;                                       // [RULE9] [RULE23]
                     res.coll <= 1'b1;
                     done_tgl <= ~done_tgl;
                     state    <= IMR_IDLE;
                  end
                  else
                  begin
                     cnt   <= baud_load(cmd.reload, 1'b0);                  // [RULE5]
                     state <= IMR_RS_HIGH;
                  end
               end
            IMR_RS_HIGH:
               if (!scl2)
               begin
                  sda_rel  <= 1'b1;                                          // [RULE9] [RULE23]
                  scl_rel  <= 1'b1;
                  res.coll <= 1'b1;
                  done_tgl <= ~done_tgl;
                  state    <= IMR_IDLE;
               end
               else if (tmo)
               begin
                  sda_rel <= 1'b0;                                           // [RULE6]
                  cnt     <= baud_load(cmd.reload, 1'b0);
                  state   <= IMR_RS_SDALO;
               end
            IMR_RS_SDALO:
               if (tmo)
               begin
                  res.coll <= 1'b0;                                          // [RULE6]
                  done_tgl <= ~done_tgl;
                  state    <= IMR_IDLE;
               end
            IMR_BIT_LOW:
               if (tmo)
               begin
                  scl_rel <= 1'b1;                                           // [RULE12] [RULE19]
                  state   <= IMR_BIT_UP;
               end
               // first bit lands once the clock is seen low; a reload under two leaves no room for it
               else if (!scl2 && !rx_mode && bitn == BIT_FIRST)
                  sda_rel <= shreg[7];                                       // [RULE12]
            IMR_BIT_UP:
               // slave may stretch the clock; the high period starts when seen high
               if (scl2)
               begin
                  cnt   <= baud_load(cmd.reload, 1'b0);
                  state <= IMR_BIT_HI;
               end
            IMR_BIT_HI:
               if (tmo)
               begin
                  scl_rel <= 1'b0;
                  cnt     <= baud_load(cmd.reload, 1'b0);
                  bitn    <= bitn + 4'h1;
                  state   <= IMR_BIT_LOW;
                  if (rx_mode)
                  begin
                     shreg <= {shreg[6:0], sda2};                            // [RULE19]
                     if (bitn == LAST_BIT)
                     begin
                        res.coll <= 1'b0;                                    // [RULE20]
                        res.data <= {shreg[6:0], sda2};
                        done_tgl <= ~done_tgl;
                        state    <= IMR_IDLE;
                     end
                  end
                  else if (bitn == ACK_SLOT)
                  begin
                     res.coll <= 1'b0;                                       // [RULE14] [RULE15]
                     res.ack  <= sda2;
                     done_tgl <= ~done_tgl;
                     state    <= IMR_IDLE;
                  end
                  else if (bitn == LAST_BIT)
                  begin
                     sda_rel   <= 1'b1;                                      // [RULE13]
                     bfclr_tgl <= ~bfclr_tgl;
                  end
                  else
                  begin
                     shreg   <= {shreg[6:0], 1'b0};                          // [RULE12] [RULE16]
                     sda_rel <= shreg[6];
                  end
               end
            default:
               state <= IMR_IDLE;
         endcase
      end
   end

   sequence s_rs_rise;
      state == IMR_RS_SCLUP && scl2 && sda2;
   endsequence

   a_write_collision_flag_on_busy: assert property (@(posedge clk_sys_in) disable iff (reset_in)   // [RULE1]
      wr_buffer_in && busy && !done_now |=> status.write_collision_flag && $stable(buffer))
      else $error("busy buffer write not refused");
   a_ctrl_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)   // [RULE2]
      ctrl_wr_in && busy && !done_now |=> $stable(request))
      else $error("request write taken while busy");
   a_write_starts: assert property (@(posedge clk_sys_in) disable iff (reset_in)   // [RULE11]
      wr_ok |=> status.buffer_full_flag && busy && cmd.kind == IMR_CMD_TX)
      else $error("buffer write did not start transmit");
   a_read_clears: assert property (@(posedge clk_sys_in) disable iff (reset_in)    // [RULE21]
      rd_buffer_in && !wr_ok && !done_now |=> !status.buffer_full_flag)
      else $error("buffer read left full flag set");
   a_rs_clock_low: assert property (@(posedge clk_link_in) disable iff (lrst2)    // [RULE3]
      state == IMR_IDLE && go && cmd.kind == IMR_CMD_RS |=> !scl_rel && state == IMR_RS_LOW)
      else $error("repeat start did not pull clock low");
   a_rs_short_load: assert property (@(posedge clk_link_in) disable iff (lrst2)   // [RULE4]
      state == IMR_RS_LOW && !scl2 |=> sda_rel && cnt == {1'b0, cmd.reload[RS_LOAD_W-1:0]})
      else $error("repeat start load wrong");
   a_rs_high_load: assert property (@(posedge clk_link_in) disable iff (lrst2)    // [RULE5]
      s_rs_rise |=> state == IMR_RS_HIGH && cnt == cmd.reload ##1 scl_rel)
      else $error("clock high reload wrong");
   a_rs_collision: assert property (@(posedge clk_link_in) disable iff (lrst2)    // [RULE9]
      state == IMR_RS_HIGH && !scl2 |=> scl_rel && sda_rel && res.coll && state == IMR_IDLE)
      else $error("early clock fall not a collision");
   a_ack_sample: assert property (@(posedge clk_link_in) disable iff (lrst2)      // [RULE14]
      state == IMR_BIT_HI && tmo && !rx_mode && bitn == ACK_SLOT |=> res.ack == $past(sda2) && !scl_rel)
      else $error("ack not sampled at ninth clock");
   a_baud_twice: assert property (@(posedge clk_link_in) disable iff (lrst2)      // [RULE24]
      state == IMR_BIT_LOW && tick && cnt != BAUD_ZERO && !tmo |=> !tick ##1 cnt == $past(cnt, 2) - 7'h01)
      else $error("baud counter rate wrong");
endmodule : imr_master

//--- hw/imr_pkg.sv
/*
 * shared constants and carriers for the two-wire master sequencer.
 * assumes one host domain and one link (quarter-cycle) domain.
 */
package imr_pkg;
   localparam int          REQ_W        = 5;
   localparam int          REQ_RS_BIT   = 1;
   localparam int          REQ_RX_BIT   = 3;
   localparam int          BAUD_W       = 7;
   localparam int          RS_LOAD_W    = 6;
   localparam logic [3:0]  LAST_BIT     = 4'h7;
   localparam logic [3:0]  ACK_SLOT     = 4'h8;
   localparam logic [3:0]  BIT_FIRST    = 4'h0;
   localparam logic [1:0]  PHASE_FIRST  = 2'h0;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [6:0]  BAUD_ZERO    = 7'h00;

   typedef enum logic [1:0]
   {
      IMR_CMD_TX = 2'b00,
      IMR_CMD_RS = 2'b01,
      IMR_CMD_RX = 2'b10
   } imr_cmd_t;

   typedef struct packed
   {
      imr_cmd_t           kind;
      logic [BAUD_W-1:0]  reload;
      logic [7:0]         data;
   } imr_req_t;

   typedef struct packed
   {
      logic        coll;
      logic        ack;
      logic [7:0]  data;
   } imr_res_t;

   typedef struct packed
   {
      logic  collision_flag;
      logic  write_collision_flag;
      logic  ack_received_bit;
      logic  start_seen;
      logic  port_event_flag;
      logic  buffer_full_flag;
   } imr_status_t;

   typedef enum logic [3:0]
   {
      IMR_IDLE     = 4'b0000,
      IMR_RS_LOW   = 4'b0001,
      IMR_RS_SDAHI = 4'b0010,
      IMR_RS_SCLUP = 4'b0011,
      IMR_RS_HIGH  = 4'b0100,
      IMR_RS_SDALO = 4'b0101,
      IMR_BIT_LOW  = 4'b0110,
      IMR_BIT_UP   = 4'b0111,
      IMR_BIT_HI   = 4'b1000
   } imr_state_t;
endpackage : imr_pkg

//--- testbench/imr_slave.sv
/*
 * slave model on the two wires: acks written bytes, sends one byte on reads.
 * assumes pull-ups on both lines and an arm pulse before each transfer.
 */
`timescale 1ns/100ps
module imr_slave
(
   input  wire logic       arm_in,
   input  wire logic       rx_mode_in,
   input  wire logic       ack_en_in,
   input  wire logic       jam_in,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       scl_oe_n_in,
   input  wire logic       sda_oe_n_in,
   output logic            scl_out,
   output logic            sda_out
);
   logic [3:0] rise_cnt;
   logic       pull_low;
   // pull-ups: a released line reads high
   assign scl_out = scl_oe_n_in;
   assign sda_out = sda_oe_n_in & ~pull_low & ~jam_in;
   always_ff @(posedge scl_out or posedge arm_in)
   begin
      if (arm_in)
         rise_cnt <= 4'h0;
      else
         rise_cnt <= rise_cnt + 4'h1;
   end
   // data only moves while the clock is low
   always_ff @(negedge scl_out or posedge arm_in)
   begin
      if (arm_in)
         pull_low <= rx_mode_in & ~tx_byte_in[7];
      else if (rx_mode_in)
         pull_low <= (rise_cnt < 4'h8) && !tx_byte_in[3'h7 - rise_cnt[2:0]];
      else
         pull_low <= ack_en_in && (rise_cnt == 4'h8);
   end
endmodule : imr_slave

//--- testbench/testbench.sv
/*
 * self-checking bench for the two-wire master with a slave model on the wires.
 * assumes a 125 MHz host clock and an unrelated 12 ns link clock.
 */
`timescale 1ns/100ps
module testbench;
   import imr_pkg::*;
   logic        clk_sys_in = 0, clk_link_in = 0, reset_in = 1, rx_m = 0, ack_en = 1, jam = 0;
   logic [6:0]  k = 7'h00;
   logic [7:0]  wdata = 8'h00, rd_data;
   logic [8:0]  cap = 9'h000;
   logic [4:0]  req;
   imr_status_t st;
   logic        scl, sda, scl_oe_n, sda_oe_n;
   int          failures = 0, check_count = 0;
   always #4 clk_sys_in = ~clk_sys_in;
   initial
   begin
      #1.7;
      forever #6 clk_link_in = ~clk_link_in;
   end
   always @(posedge scl) cap <= {cap[7:0], sda};
   imr_master dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_link_in(clk_link_in),
      .wr_buffer_in(k[0]), .wr_data_in(wdata), .rd_buffer_in(k[2]), .ctrl_wr_in(k[1]),
      .ctrl_data_in(wdata[4:0]), .baud_reload_in(7'h41), .write_collision_flag_clear_in(k[5]), .event_clear_in(k[4]),
      .coll_clear_in(k[6]), .rd_data_out(rd_data), .status_out(st), .request_out(req), .scl_in(scl),
      .scl_out(), .scl_oe_n_out(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n_out(sda_oe_n));
   imr_slave slave (.arm_in(k[3]), .rx_mode_in(rx_m), .ack_en_in(ack_en), .jam_in(jam),
      .tx_byte_in(8'h3c), .scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda));
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // k bits: coll_clr write_collision_flag_clr ev_clr arm rd ctrl wr
   task op(input logic [6:0] kv, input logic [7:0] d);
      @(posedge clk_sys_in) k <= kv;
      wdata <= d;
      @(posedge clk_sys_in) k <= 7'h00;
      @(negedge clk_sys_in);
   endtask : op
   task wait_done();
      int n;
      for (n = 0; n < 20000 && st.port_event_flag !== 1'b1 && st.collision_flag !== 1'b1; n++)
         @(posedge clk_sys_in);
      if (n == 20000)
      begin
         failures++;
         summarize();
      end
      repeat (2) @(posedge clk_sys_in);
   endtask : wait_done
   task t_rs();
      op(7'h0a, 8'h02);
      check("rs request", {3'h0, req}, 8'h02);
      op(7'h01, 8'h55);
      op(7'h02, 8'h08);
      wait_done();
      check("write_collision_flag", {7'h0, st.write_collision_flag}, 8'h01);
      check("buffer kept", rd_data, 8'h00);
      check("requests", {3'h0, req}, 8'h00);
      check("start seen", {7'h0, st.start_seen}, 8'h01);
      check("lines", {6'h0, scl_oe_n, sda_oe_n}, 8'h02);
      op(7'h10, 8'h00);
   endtask : t_rs
   task t_tx(input logic [7:0] d, input logic ack);
      ack_en = ack;
      op(7'h09, d);
      check("full", {7'h0, st.buffer_full_flag}, 8'h01);
      wait_done();
      check("wire byte", cap[8:1], d);
      check("ack bit", {7'h0, st.ack_received_bit}, {7'h0, !ack});
      check("emptied", {7'h0, st.buffer_full_flag}, 8'h00);
      check("held", {6'h0, scl_oe_n, sda_oe_n}, 8'h01);
      op(7'h10, 8'h00);
   endtask : t_tx
   task t_rx();
      rx_m = 1;
      op(7'h0a, 8'h08);
      wait_done();
      check("rx byte", rd_data, 8'h3c);
      check("rx full", {st.port_event_flag, st.buffer_full_flag, req, scl_oe_n}, 8'hc0);
      op(7'h14, 8'h00);
      check("read clears", {7'h0, st.buffer_full_flag}, 8'h00);
      op(7'h02, 8'h10);
      check("ack request", {3'h0, req}, 8'h00);
      rx_m = 0;
   endtask : t_rx
   task t_coll();
      jam = 1;
      op(7'h0a, 8'h02);
      wait_done();
      check("collision", {7'h0, st.collision_flag}, 8'h01);
      check("released", {1'h0, req, scl_oe_n, sda_oe_n}, 8'h03);
      jam = 0;
   endtask : t_coll
   task summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (8) @(posedge clk_sys_in);
      reset_in <= 0;
      repeat (6) @(posedge clk_sys_in);
      check("reset", {st, scl_oe_n, sda_oe_n}, 8'h03);
      t_rs();
      t_tx(8'ha4, 1'b1);
      t_tx(8'h5b, 1'b0);
      check("write_collision_flag sticky", {7'h0, st.write_collision_flag}, 8'h01);
      op(7'h20, 8'h00);
      check("write_collision_flag cleared", {7'h0, st.write_collision_flag}, 8'h00);
      t_rx();
      t_coll();
      summarize();
   end
endmodule : testbench
